/* File: core/ebus_regs.svh */
// register offsets, field positions and reset values for the external bus port block
`ifndef EBUS_REGS_SVH
`define EBUS_REGS_SVH
`define OFS_GPIO_A_DATA 16'h0000
`define OFS_GPIO_A_DIRECTION 16'h0002
`define OFS_PORT_E_DATA 16'h0008
`define OFS_PORT_E_DIRECTION 16'h0009
`define OFS_BUS_CTRL 16'h0040
`define OFS_BUS_STATUS 16'h0044
`define OFS_EXP_REG_LIMIT 16'h0010
`define RST_GPIO_A_DIRECTION 8'h00
`define RST_BUS_CTRL 8'h00
`define CTRL_MODE_LSB 0
`define CTRL_NARROW_BIT 2
`define CTRL_FOLLOW_BIT 3
`define CTRL_EME_BIT 4
`define ADDR_W 16
`define FOLLOW_BASE 16'h0400
`define FOLLOW_TOP 16'h07FF
`define RAM_BASE 16'h2000
`define RAM_TOP 16'h3FFF
`endif

/* File: core/ebus_pkg.sv */
// types for the external bus port block
package ebus_pkg;
    typedef enum logic [1:0]
    {
        MODE_SINGLE,
        MODE_EXPANDED,
        MODE_PERIPHERAL
    } op_mode_e;
    typedef enum logic
    {
        BUS_IDLE,
        BUS_EXT
    } bus_state_e;
endpackage : ebus_pkg

/* File: core/ebus_strobe_enc.sv */
// size and alignment encoder for the external bus control pins
`timescale 1ns/1ps
`default_nettype none
module ebus_strobe_enc
(
    input wire logic is_word,
    input wire logic addr0,
    input wire logic is_read,
    input wire logic [15:0] wdata_in,
    output logic strobe_n,
    output logic a0,
    output logic rw,
    output logic [15:0] wdata_out
);
    assign strobe_n = is_word ? addr0 : ~addr0;
    assign a0 = addr0;
    assign rw = is_read;
    // misaligned word: accessed byte low, next byte high
    assign wdata_out = (is_word && addr0) ? {wdata_in[7:0], wdata_in[15:8]} : wdata_in;
endmodule : ebus_strobe_enc
`default_nettype wire

/* File: core/ebus_port_ctrl.sv */
// external multiplexed bus control with port A general purpose I/O
// Function
// - 16-bit internal paths; external bus 8 or 16 bits by mode and control.
// - byte and word accesses may be adjacent; size shown on low byte strobe.
// - wide expanded mode narrows register-following space when follow bit set.
// - strobe and A0 both high only for internal RAM misaligned words.
// - misaligned RAM word: accessed byte on low half, next on high.
// - byte access encoding of strobe, A0 and read/write.
// - word access encoding of strobe, A0 and read/write.
// - peripheral mode removes the first sixteen expansion registers.
// - expanded modes send port A/B register accesses externally.
// - expanded with emulate bit sends port E registers externally.
// - port A is GPIO single chip, else high address/data, narrow low data.
// - port A data readable in single chip only, writable unless expanded; direction follows register bit.
// - direction 0 input, 1 output; resets to zero.
// - direction register absent in expanded/peripheral modes, else accessible.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`include "ebus_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ebus_port_ctrl
    import ebus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [1:0] avs_byteenable,
    input wire logic [15:0] avs_writedata,
    output logic [15:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe,
    output logic [7:0] port_b_pins_out,
    output logic [7:0] port_b_pins_oe,
    output logic low_byte_strobe_n,
    output logic addr0_pin,
    output logic rw_pin,
    output logic bus_phase_clock,
    output logic data_bus_enable_n,
    output logic ext_is_word,
    output logic [15:0] ext_data_q
);
    logic [7:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_in_q;
    logic [7:0] gpio_a_data_q, gpio_a_direction_q;
    logic [7:0] ctrl_q;
    bus_state_e st_q;
    logic [1:0] phase_q;
    logic [15:0] ext_addr_q;
    logic ext_word_q, ext_read_q, ext_acc_q;
    logic [15:0] rdata_d;
    logic wait_d;
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng
    wire op_mode_e mode = op_mode_e'(ctrl_q[`CTRL_MODE_LSB +: 2]);
    wire single = (mode == MODE_SINGLE);
    wire periph = (mode == MODE_PERIPHERAL);
    wire expanded = (mode == MODE_EXPANDED);
    wire narrow_bit = ctrl_q[`CTRL_NARROW_BIT];
    wire follow_bit = ctrl_q[`CTRL_FOLLOW_BIT];
    wire emulate_port_e_bit = ctrl_q[`CTRL_EME_BIT];
    wire req = avs_read | avs_write;
    wire is_word = (avs_byteenable == 2'b11);
    wire is_ram = in_rng(avs_address, `RAM_BASE, `RAM_TOP);
    wire is_follow = in_rng(avs_address, `FOLLOW_BASE, `FOLLOW_TOP);
    wire is_pa_reg = (avs_address == `OFS_GPIO_A_DATA) || (avs_address == `OFS_GPIO_A_DIRECTION);
    wire is_pb_reg = (avs_address == 16'h0001) || (avs_address == 16'h0003);
    wire is_pe_reg = (avs_address == `OFS_PORT_E_DATA) || (avs_address == `OFS_PORT_E_DIRECTION);
    wire is_ctl_reg = (avs_address == `OFS_BUS_CTRL) || (avs_address == `OFS_BUS_STATUS);
    // lowest sixteen registers vanish in peripheral mode
    wire removed_periph = periph && (avs_address < `OFS_EXP_REG_LIMIT);
    // port A/B registers become external in expanded mode
    wire removed_ab = expanded && (is_pa_reg || is_pb_reg);
    // port E registers external only with emulate bit
    wire removed_e = expanded && emulate_port_e_bit && is_pe_reg;
    wire go_ext = !is_ctl_reg && !is_ram && (removed_ab || removed_e ||
        (expanded && avs_address >= `OFS_EXP_REG_LIMIT));
    // wide unless narrow mode; follow space narrowed
    wire narrow_now = narrow_bit || (follow_bit && is_follow);
    wire pa_visible = single && (avs_address == `OFS_GPIO_A_DATA);
    // direction register mapped only in single chip mode
    wire dir_visible = single && (avs_address == `OFS_GPIO_A_DIRECTION);
    wire enc_strobe_n, enc_a0, enc_rw;
    wire [15:0] enc_wdata;
    ebus_strobe_enc u_enc
    (
        .is_word(is_word),
        .addr0(avs_address[0]),
        .is_read(avs_read),
        .wdata_in(avs_writedata),
        .strobe_n(enc_strobe_n),
        .a0(enc_a0),
        .rw(enc_rw),
        .wdata_out(enc_wdata)
    );
    always_ff @(posedge clk_sys)
    begin
        pa_s1_q <= port_a_pins_in;
        pa_s2_q <= pa_s1_q;
        pa_s3_q <= pa_s2_q;
        if (pa_s2_q == pa_s3_q)
        begin
            pa_in_q <= pa_s3_q;
        end
    end
    // read returns pin level for inputs, latch for outputs
    wire [7:0] pa_read = (gpio_a_direction_q & gpio_a_data_q) | (~gpio_a_direction_q & pa_in_q);
    always_comb
    begin
        rdata_d = 16'h0000;
        wait_d = 1'b0;
        if (st_q == BUS_IDLE && req && go_ext && !removed_periph)
        begin
            wait_d = 1'b1;
        end
        else if (pa_visible)
        begin
            rdata_d = {8'h00, pa_read};
        end
        else if (dir_visible)
        begin
            rdata_d = {8'h00, gpio_a_direction_q};
        end
        else if (avs_address == `OFS_BUS_CTRL)
        begin
            rdata_d = {8'h00, ctrl_q};
        end
        else if (avs_address == `OFS_BUS_STATUS)
        begin
            rdata_d = {14'h0000, ext_acc_q, narrow_now};
        end
    end
    // first cycle of an external access stalls; second completes
    assign avs_waitrequest = wait_d;
    assign avs_readdata = rdata_d;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_q <= BUS_IDLE;
            gpio_a_direction_q <= `RST_GPIO_A_DIRECTION;
            gpio_a_data_q <= 8'h00;
            ctrl_q <= `RST_BUS_CTRL;
            phase_q <= 2'b00;
            ext_acc_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_q + 2'b01;
            st_q <= wait_d ? BUS_EXT : BUS_IDLE;
            ext_acc_q <= wait_d;
            if (avs_write && !wait_d)
            begin
                if (avs_address == `OFS_GPIO_A_DATA && !go_ext)
                begin
                    gpio_a_data_q <= avs_writedata[7:0];
                end
                if (dir_visible)
                begin
                    gpio_a_direction_q <= avs_writedata[7:0];
                end
                if (avs_address == `OFS_BUS_CTRL)
                begin
                    ctrl_q <= avs_writedata[7:0];
                end
            end
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ext_addr_q <= 16'h0000;
            ext_word_q <= 1'b0;
            ext_read_q <= 1'b1;
            low_byte_strobe_n <= 1'b1;
            addr0_pin <= 1'b0;
            rw_pin <= 1'b1;
            ext_data_q <= 16'h0000;
        end
        else if (wait_d || (req && is_ram))
        begin
            ext_addr_q <= avs_address;
            ext_word_q <= is_word && !narrow_now;
            ext_read_q <= avs_read;
            // size shown per access; misaligned words only in RAM
            low_byte_strobe_n <= (is_word && avs_address[0] && !is_ram) ? 1'b0 : enc_strobe_n;
            addr0_pin <= enc_a0;
            rw_pin <= enc_rw;
            ext_data_q <= enc_wdata;
        end
    end
    assign ext_is_word = ext_word_q;
    wire drive_data = (st_q == BUS_EXT) && !ext_read_q;
    // port A function by mode; pin direction from register in single chip mode only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port_a_pins_out <= 8'h00;
            port_a_pins_oe <= 8'h00;
            port_b_pins_out <= 8'h00;
            port_b_pins_oe <= 8'h00;
            bus_phase_clock <= 1'b0;
            data_bus_enable_n <= 1'b1;
        end
        else
        begin
            // phase clock and data enable let outside logic split address/data
            bus_phase_clock <= phase_q[1];
            data_bus_enable_n <= !(st_q == BUS_EXT);
            if (single)
            begin
                port_a_pins_out <= gpio_a_data_q;
                port_a_pins_oe <= gpio_a_direction_q;
                port_b_pins_out <= 8'h00;
                port_b_pins_oe <= 8'h00;
            end
            else
            begin
                port_a_pins_oe <= (st_q == BUS_EXT) ? {8{drive_data}} : 8'hFF;
                port_b_pins_oe <= (st_q == BUS_EXT) ? {8{drive_data && ext_word_q}} : 8'hFF;
                if (st_q == BUS_EXT)
                begin
                    port_a_pins_out <= ext_word_q ? ext_data_q[15:8] : ext_data_q[7:0];
                    port_b_pins_out <= ext_data_q[7:0];
                end
                else
                begin
                    // new address shows at once, ahead of its data phase
                    port_a_pins_out <= wait_d ? avs_address[15:8] : ext_addr_q[15:8];
                    port_b_pins_out <= wait_d ? avs_address[7:0] : ext_addr_q[7:0];
                end
            end
        end
    end
    chk_dir_reset: assert property (@(posedge clk_sys)
        $past(rst) |-> gpio_a_direction_q == 8'h00)
        else $error("direction not cleared by reset");
    chk_pa_oe: assert property (@(posedge clk_sys) disable iff (rst)
        $past(single) && !$past(rst) |-> port_a_pins_oe == $past(gpio_a_direction_q))
        else $error("port A enable does not follow direction");
    chk_ext_stall: assert property (@(posedge clk_sys) disable iff (rst)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("external access stall too long");
    chk_dir_hidden: assert property (@(posedge clk_sys) disable iff (rst)
        !single && avs_write && avs_address == `OFS_GPIO_A_DIRECTION
        |=> $stable(gpio_a_direction_q))
        else $error("direction written while unmapped");
    chk_misalign_ram: assert property (@(posedge clk_sys) disable iff (rst)
        low_byte_strobe_n && addr0_pin |-> in_rng(ext_addr_q, `RAM_BASE, `RAM_TOP))
        else $error("misaligned strobe outside RAM");
    chk_byte_enc: assert property (@(posedge clk_sys) disable iff (rst)
        ext_acc_q && !ext_word_q && !$past(narrow_now) |-> low_byte_strobe_n != addr0_pin)
        else $error("byte strobe encoding wrong");
    chk_periph_gone: assert property (@(posedge clk_sys) disable iff (rst)
        periph && req && avs_address < `OFS_EXP_REG_LIMIT |-> !avs_waitrequest)
        else $error("removed register reached the bus");
    chk_dbe_ext: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == BUS_EXT |=> !data_bus_enable_n)
        else $error("data enable missing in external cycle");
    chk_word_even: assert property (@(posedge clk_sys) disable iff (rst)
        ext_acc_q && ext_word_q && !addr0_pin |-> !low_byte_strobe_n)
        else $error("even word strobe not low");
    chk_rw_follows: assert property (@(posedge clk_sys) disable iff (rst)
        ext_acc_q |-> rw_pin == $past(avs_read))
        else $error("read write pin does not follow request");
    chk_dir_write: assert property (@(posedge clk_sys) disable iff (rst)
        single && avs_write && !avs_waitrequest && avs_address == `OFS_GPIO_A_DIRECTION
        |=> gpio_a_direction_q == $past(avs_writedata[7:0]))
        else $error("direction write lost");
    // pins carry address outside single chip after each idle bus cycle
    chk_pa_addr: assert property (@(posedge clk_sys) disable iff (rst)
        !single && st_q == BUS_IDLE |=> port_a_pins_oe == 8'hFF)
        else $error("port A not driving address");
    chk_ab_external: assert property (@(posedge clk_sys) disable iff (rst)
        req && expanded && (is_pa_reg || is_pb_reg) && st_q == BUS_IDLE |-> avs_waitrequest)
        else $error("port register stayed internal in expanded mode");
    chk_pe_external: assert property (@(posedge clk_sys) disable iff (rst)
        req && is_pe_reg && st_q == BUS_IDLE
        |-> avs_waitrequest == (expanded && emulate_port_e_bit))
        else $error("port E routing wrong");
    chk_ram_internal: assert property (@(posedge clk_sys) disable iff (rst)
        req && is_ram |-> !avs_waitrequest)
        else $error("RAM access stalled as external");
endmodule : ebus_port_ctrl
`default_nettype wire

/* File: test/ebus_far_model.sv */
// far side model: pin pads and bus cycle decoder
`timescale 1ns/1ps
`default_nettype none
`include "ebus_regs.svh"
module ebus_far_model
(
    input wire logic clk_sys,
    input wire logic [7:0] pad_val,
    input wire logic [7:0] pins_out,
    input wire logic [7:0] pins_b_out,
    input wire logic [7:0] pins_oe,
    input wire logic low_byte_strobe_n,
    input wire logic addr0_pin,
    input wire logic rw_pin,
    input wire logic data_bus_enable_n,
    output logic [7:0] pins_in,
    output logic [2:0] acc_code,
    output logic [7:0] pru_dir
);
    logic [15:0] addr_q;
    // undriven bits show the pad level
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & pad_val);
    always_ff @(posedge clk_sys)
    begin
        if (data_bus_enable_n)
        begin
            addr_q <= {pins_out, pins_b_out};
        end
        else
        begin
            acc_code <= {low_byte_strobe_n, addr0_pin, rw_pin};
            if (!rw_pin && addr_q == `OFS_GPIO_A_DIRECTION)
            begin
                pru_dir <= pins_out;
            end
        end
    end
endmodule : ebus_far_model
`default_nettype wire

/* File: test/ebus_port_ctrl_tb.sv */
// self-checking bench for the external bus port block
`timescale 1ns/1ps
`default_nettype none
`include "ebus_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ebus_port_ctrl_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] avs_address = 16'h0000;
    logic [15:0] avs_writedata = 16'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [1:0] avs_byteenable = 2'h0;
    logic [7:0] pad_val = 8'h3C;
    logic [15:0] rv;
    logic [2:0] snap;
    int n_fail = 0;
    int checks = 0;
    int n_edges = 0;
    wire logic [15:0] avs_readdata, ext_data_q;
    wire logic [7:0] pins_in, pins_out, pins_oe, pins_b_out, pru_dir;
    wire logic [2:0] acc_code;
    wire logic avs_waitrequest, low_byte_strobe_n, addr0_pin, rw_pin, dbe_n, ext_is_word;
    ebus_port_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_a_pins_in(pins_in),
        .port_a_pins_out(pins_out), .port_a_pins_oe(pins_oe), .port_b_pins_out(pins_b_out),
        .port_b_pins_oe(), .low_byte_strobe_n(low_byte_strobe_n), .addr0_pin(addr0_pin),
        .rw_pin(rw_pin), .bus_phase_clock(), .data_bus_enable_n(dbe_n),
        .ext_is_word(ext_is_word), .ext_data_q(ext_data_q));
    ebus_far_model u_far (.clk_sys(clk_sys), .pad_val(pad_val), .pins_out(pins_out),
        .pins_b_out(pins_b_out), .pins_oe(pins_oe), .low_byte_strobe_n(low_byte_strobe_n),
        .addr0_pin(addr0_pin), .rw_pin(rw_pin), .data_bus_enable_n(dbe_n), .pins_in(pins_in),
        .acc_code(acc_code), .pru_dir(pru_dir));
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic give_verdict;
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // one request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [1:0] be,
        input logic [15:0] wd);
        int n;
        logic wt;
        n = 0;
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        do
        begin
            @(posedge clk_sys);
            wt = avs_waitrequest;
            rv = avs_readdata;
            n++;
        end
        while (wt !== 1'b0 && n < 50);
        n_edges = n;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
        snap = {low_byte_strobe_n, addr0_pin, rw_pin};
        if (wt !== 1'b0)
        begin
            `CHK("waitrequest", 1'b0, wt)
            give_verdict();
        end
    endtask : acc
    task automatic t_reset;
        acc(1'b0, `OFS_GPIO_A_DIRECTION, 2'b01, 16'h0000);
        `CHK("dir_reset", `RST_GPIO_A_DIRECTION, rv[7:0])
        `CHK("oe_reset", 8'h00, pins_oe)
    endtask : t_reset
    task automatic t_gpio;
        acc(1'b1, `OFS_GPIO_A_DIRECTION, 2'b01, 16'h00F0);
        acc(1'b1, `OFS_GPIO_A_DATA, 2'b01, 16'h00A5);
        @(posedge clk_sys);
        `CHK("oe", 8'hF0, pins_oe)
        `CHK("pins_out", 8'hA0, pins_out & 8'hF0)
        // input path has a three flop synchroniser
        repeat (4) @(posedge clk_sys);
        acc(1'b0, `OFS_GPIO_A_DATA, 2'b01, 16'h0000);
        `CHK("data_read", 8'hAC, rv[7:0])
    endtask : t_gpio
    task automatic t_expand;
        logic [15:0] ta [6] = '{16'h1000, 16'h1001, 16'h1000, 16'h1001, 16'h1000, 16'h1000};
        logic [1:0] tb [6] = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b11, 2'b11};
        logic tw [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [2:0] tc [6] = '{3'b101, 3'b011, 3'b100, 3'b010, 3'b001, 3'b000};
        acc(1'b1, `OFS_BUS_CTRL, 2'b01, 16'h0001);
        acc(1'b0, `OFS_GPIO_A_DIRECTION, 2'b01, 16'h0000);
        `CHK("dir_exp", 16'h0000, rv)
        acc(1'b1, `OFS_GPIO_A_DIRECTION, 2'b01, 16'h00FF);
        @(posedge clk_sys);
        `CHK("pru_dir", 8'hFF, pru_dir)
        for (int i = 0; i < 6; i++)
        begin
            acc(tw[i], ta[i], tb[i], 16'h1234);
            @(posedge clk_sys);
            `CHK("acc_code", tc[i], acc_code)
        end
        `CHK("ext_data", 16'h1234, ext_data_q)
        `CHK("ext_word", 1'b1, ext_is_word)
        acc(1'b0, 16'h2001, 2'b11, 16'h0000);
        `CHK("ram_odd_word", 3'b111, snap)
        acc(1'b1, 16'h2001, 2'b11, 16'h1234);
        `CHK("ram_swap", 16'h3412, ext_data_q)
        `CHK("ram_odd_write", 3'b110, snap)
        acc(1'b1, `OFS_BUS_CTRL, 2'b01, 16'h0000);
        acc(1'b0, `OFS_GPIO_A_DIRECTION, 2'b01, 16'h0000);
        `CHK("dir_kept", 8'hF0, rv[7:0])
    endtask : t_expand
    task automatic t_periph;
        acc(1'b1, `OFS_PORT_E_DATA, 2'b01, 16'h005A);
        acc(1'b1, `OFS_BUS_CTRL, 2'b01, 16'h0002);
        acc(1'b0, `OFS_PORT_E_DATA, 2'b01, 16'h0000);
        `CHK("pe_periph", 16'h0000, rv)
        `CHK("pe_periph_int", 1, n_edges)
        acc(1'b0, `OFS_GPIO_A_DATA, 2'b01, 16'h0000);
        `CHK("pa_periph", 16'h0000, rv)
    endtask : t_periph
    task automatic t_eme;
        acc(1'b1, `OFS_BUS_CTRL, 2'b01, 16'h0011);
        acc(1'b0, `OFS_PORT_E_DATA, 2'b01, 16'h0000);
        `CHK("pe_eme_wait", 2, n_edges)
        @(posedge clk_sys);
        `CHK("pe_eme", 16'h0000, rv)
        `CHK("pe_ext", 3'b101, acc_code)
        acc(1'b1, `OFS_BUS_CTRL, 2'b01, 16'h0001);
        acc(1'b0, `OFS_PORT_E_DATA, 2'b01, 16'h0000);
        `CHK("pe_internal", 1, n_edges)
        `CHK("pe_kept", 8'h00, rv[7:0])
    endtask : t_eme
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_gpio();
        t_expand();
        t_periph();
        t_eme();
        give_verdict();
    end
endmodule : ebus_port_ctrl_tb
`default_nettype wire
